/* core/timer_pkg.sv */
// Constants, register map and types of the asynchronous 8-bit timer.
// Assumes a 32-bit classic Wishbone slave with byte addresses on ADR_I.
//
// Overview of operation
// - Each buffered register write waits in its own temp, lands after two osc edges.
// - Status register shows one busy flag per buffered register until transfer done.
// - Compare matching is suppressed while a count, compare A or compare B write is pending.
// - Source is I/O clock by default; async select uses osc pin, detaches port.
// - Prescaler offers stop, divide by 1, 8, 32, 64, 128, 256, 1024.
// - Writing 1 to the prescaler reset bit restarts prescaler phase.
// - Oscillator runs in all sleep modes but deep sleep (DEEP_SLEEP_I).
// - Wake-up starts on next timer tick; processor then stalls four cycles.
// - Counter reads come from a copy refreshed on each osc edge, frozen in sleep.
// - Flags take three processor cycles plus a tick; output pin changes on tick.
// - Nonzero channel A output mode overrides port; driver needs direction bit.
// - Non-PWM modes: off, toggle, clear or set on match.
// - Fast PWM: clear/set on match and inverse at bottom; toggle only with compare top.
// - Fast PWM clear/set with compare A at top: match ignored, bottom action still done.
// - Phase correct: mode 10 clears counting up, sets counting down; 11 opposite.
// - Waveform field selects normal, phase correct, CTC, fast PWM; 4 and 6 reserved.
// - Fast PWM counts bottom to top, restarts at bottom on next tick.
// - Phase correct counts up then down, holding top exactly one tick.

package timer_pkg;

	// ----------------------------------------
	// Register byte addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL_A = 8'hB0;
	localparam logic [7:0] ADDR_CTRL_B = 8'hB4;
	localparam logic [7:0] ADDR_COUNT = 8'hB8;
	localparam logic [7:0] ADDR_CMP_A = 8'hBC;
	localparam logic [7:0] ADDR_CMP_B = 8'hC0;
	localparam logic [7:0] ADDR_STATUS = 8'hC4;
	localparam logic [7:0] ADDR_GEN_CTRL = 8'hC8;
	localparam logic [7:0] ADDR_FLAGS = 8'hCC;

	// ----------------------------------------
	// Buffered register indices, equal to busy bit positions
	// ----------------------------------------
	localparam int BUF_CTRL_B = 0;
	localparam int BUF_CTRL_A = 1;
	localparam int BUF_CMP_B = 2;
	localparam int BUF_CMP_A = 3;
	localparam int BUF_COUNT = 4;
	localparam int BUF_NUM = 5;

	// ----------------------------------------
	// Field positions and masks
	// ----------------------------------------
	localparam int ST_ASYNC_BIT = 5;
	localparam int GEN_PSR_BIT = 1;
	localparam int FLAG_OVF = 0;
	localparam int FLAG_CMP_A = 1;
	localparam int FLAG_CMP_B = 2;
	localparam int FLAG_NUM = 3;
	localparam logic [7:0] CTRL_A_MASK = 8'hF3;
	localparam logic [7:0] CTRL_B_MASK = 8'h0F;
	localparam logic [7:0] RESET_VAL = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam logic [0:0] XFER_LAST_EDGE = 1'h1;
	localparam int FLAG_SYNC_CYCLES = 3;
	localparam logic [2:0] WAKE_STALL_CYCLES = 3'h4;

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	localparam int PRESC_W = 10;
	localparam logic [9:0] DIV1_MASK = 10'h000;
	localparam logic [9:0] DIV8_MASK = 10'h007;
	localparam logic [9:0] DIV32_MASK = 10'h01F;
	localparam logic [9:0] DIV64_MASK = 10'h03F;
	localparam logic [9:0] DIV128_MASK = 10'h07F;
	localparam logic [9:0] DIV256_MASK = 10'h0FF;
	localparam logic [9:0] DIV1024_MASK = 10'h3FF;

	typedef enum logic [2:0] {
		CS_STOP = 3'b000,
		CS_DIV1 = 3'b001,
		CS_DIV8 = 3'b010,
		CS_DIV32 = 3'b011,
		CS_DIV64 = 3'b100,
		CS_DIV128 = 3'b101,
		CS_DIV256 = 3'b110,
		CS_DIV1024 = 3'b111
	} clk_sel_t;

	typedef enum logic [2:0] {
		WM_NORMAL = 3'b000,
		WM_PC_MAX = 3'b001,
		WM_CTC = 3'b010,
		WM_FAST_MAX = 3'b011,
		WM_RSV4 = 3'b100,
		WM_PC_CMP = 3'b101,
		WM_RSV6 = 3'b110,
		WM_FAST_CMP = 3'b111
	} wave_mode_t;

	typedef enum logic [1:0] {
		OM_OFF = 2'b00,
		OM_TOGGLE = 2'b01,
		OM_CLEAR = 2'b10,
		OM_SET = 2'b11
	} out_mode_t;

endpackage

/* core/write_xfer.sv */
// Temporary register and transfer path for one buffered timer register.
// Assumes edge_i pulses for one cycle at each timer source edge.
`timescale 1ns/10ps
`default_nettype none
module write_xfer #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic wr_i,
	input wire logic [W-1:0] wdata_i,
	input wire logic edge_i,
	output logic load_o,
	output logic [W-1:0] data_o,
	output logic busy_o
);
	logic pending_r;
	logic [0:0] ecnt_r;
	logic [W-1:0] temp_r;
	logic done_tgl_r;
	logic ack_s1_r;
	logic ack_s2_r;
	logic ack_seen_r;
	logic busy_r;

	// ----------------------------------------
	// Transfer after two source edges
	// ----------------------------------------
	assign load_o = pending_r & edge_i & ~wr_i & (ecnt_r == timer_pkg::XFER_LAST_EDGE);
	assign data_o = temp_r;
	assign busy_o = busy_r;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pending_r <= 1'b0;
			ecnt_r <= 1'h0;
			temp_r <= '0;
			done_tgl_r <= 1'b0;
		end else if (wr_i) begin
			pending_r <= 1'b1;
			ecnt_r <= 1'h0;
			temp_r <= wdata_i;
		end else if (load_o) begin
			pending_r <= 1'b0;
			done_tgl_r <= ~done_tgl_r;
		end else if (pending_r && edge_i) begin
			ecnt_r <= ecnt_r + 1'h1;
		end
	end

	// ----------------------------------------
	// Acknowledge synchroniser and busy flag
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_s1_r <= 1'b0;
			ack_s2_r <= 1'b0;
			ack_seen_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			ack_s1_r <= done_tgl_r;
			ack_s2_r <= ack_s1_r;
			ack_seen_r <= ack_s2_r;
			if (wr_i)
				busy_r <= 1'b1;
			else if (ack_s2_r != ack_seen_r)
				busy_r <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* core/presc_div.sv */
// Prescaler of the timer source clock.
// Assumes src_tick_i pulses once per timer source edge.
`timescale 1ns/10ps
`default_nettype none
module presc_div (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic src_tick_i,
	input wire logic clr_i,
	input wire logic [2:0] sel_i,
	output logic tick_o
);
	logic [timer_pkg::PRESC_W-1:0] cnt_r;
	logic [timer_pkg::PRESC_W-1:0] mask;

	function automatic logic [timer_pkg::PRESC_W-1:0] div_mask(input logic [2:0] sel);
		unique case (timer_pkg::clk_sel_t'(sel))
			timer_pkg::CS_STOP: div_mask = timer_pkg::DIV1_MASK;
			timer_pkg::CS_DIV1: div_mask = timer_pkg::DIV1_MASK;
			timer_pkg::CS_DIV8: div_mask = timer_pkg::DIV8_MASK;
			timer_pkg::CS_DIV32: div_mask = timer_pkg::DIV32_MASK;
			timer_pkg::CS_DIV64: div_mask = timer_pkg::DIV64_MASK;
			timer_pkg::CS_DIV128: div_mask = timer_pkg::DIV128_MASK;
			timer_pkg::CS_DIV256: div_mask = timer_pkg::DIV256_MASK;
			timer_pkg::CS_DIV1024: div_mask = timer_pkg::DIV1024_MASK;
		endcase
	endfunction

	// ----------------------------------------
	// Divider selection
	// ----------------------------------------
	assign mask = div_mask(sel_i);
	assign tick_o = src_tick_i & ~clr_i & (sel_i != timer_pkg::CS_STOP) & ((cnt_r & mask) == mask);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			cnt_r <= '0;
		else if (clr_i)
			cnt_r <= '0;
		else if (src_tick_i)
			cnt_r <= cnt_r + 1'b1;
	end
endmodule
`default_nettype wire

/* core/async_timer.sv */
// 8-bit timer with buffered asynchronous register writes and channel A output.
// Assumes a classic Wishbone master and an oscillator input sampled on CLK_I.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module async_timer (
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [7:0] ADR_I,
	input wire logic [3:0] SEL_I,
	input wire logic [31:0] DAT_I,
	output logic [31:0] DAT_O,
	output logic ACK_O,
	input wire logic OSC_IN_I,
	input wire logic PIN_DIR_I,
	input wire logic SLEEP_I,
	input wire logic DEEP_SLEEP_I,
	output logic CHAN_A_OUT_O,
	output logic CHAN_A_OE_O,
	output logic CHAN_A_OVERRIDE_O,
	output logic OSC_PORT_DETACH_O,
	output logic OSC_RUN_O,
	output logic [2:0] TIMER_FLAGS_O,
	output logic WAKE_O,
	output logic CPU_HALT_O
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic ack_r;
	logic [31:0] dat_r;
	logic req;
	logic wr_en;
	logic async_r;
	logic osc_d_r;
	logic osc_rise;
	logic src_tick;
	logic tick;
	logic psr_clr;
	logic [timer_pkg::BUF_NUM-1:0] wr_buf;
	logic [timer_pkg::BUF_NUM-1:0] load;
	logic [timer_pkg::BUF_NUM-1:0] busy;
	logic [7:0] temp [timer_pkg::BUF_NUM];
	logic [7:0] ctrl_a_r;
	logic [7:0] ctrl_b_r;
	logic [7:0] cmp_a_r;
	logic [7:0] cmp_b_r;
	logic [7:0] count_r;
	logic [7:0] count_rd_r;
	logic down_r;
	logic oc_r;
	logic [2:0] flags_r;
	logic [2:0] evt;
	logic [2:0] evt_d_r [timer_pkg::FLAG_SYNC_CYCLES];
	logic wake_arm_r;
	logic wake_r;
	logic [2:0] halt_cnt_r;
	logic [7:0] top;
	logic [7:0] rd_val;
	logic at_top;
	logic at_bot;
	logic suppress;
	logic match_a;
	logic match_b;
	timer_pkg::wave_mode_t mode;
	timer_pkg::out_mode_t com_a;

	function automatic logic hit(input logic [7:0] adr, input logic [7:0] target);
		hit = (adr[7:2] == target[7:2]);
	endfunction

	function automatic logic [7:0] buf_addr(input int idx);
		unique case (idx)
			timer_pkg::BUF_CTRL_B: buf_addr = timer_pkg::ADDR_CTRL_B;
			timer_pkg::BUF_CTRL_A: buf_addr = timer_pkg::ADDR_CTRL_A;
			timer_pkg::BUF_CMP_B: buf_addr = timer_pkg::ADDR_CMP_B;
			timer_pkg::BUF_CMP_A: buf_addr = timer_pkg::ADDR_CMP_A;
			default: buf_addr = timer_pkg::ADDR_COUNT;
		endcase
	endfunction

	// ----------------------------------------
	// Wishbone slave
	// ----------------------------------------
	assign req = CYC_I & STB_I;
	assign wr_en = ack_r & req & WE_I & SEL_I[0];
	assign ACK_O = ack_r;
	assign DAT_O = dat_r;

	always_comb begin
		rd_val = timer_pkg::RESET_VAL;
		if (hit(ADR_I, timer_pkg::ADDR_CTRL_A))
			rd_val = ctrl_a_r;
		else if (hit(ADR_I, timer_pkg::ADDR_CTRL_B))
			rd_val = ctrl_b_r;
		else if (hit(ADR_I, timer_pkg::ADDR_COUNT))
			rd_val = count_rd_r;
		else if (hit(ADR_I, timer_pkg::ADDR_CMP_A))
			rd_val = cmp_a_r;
		else if (hit(ADR_I, timer_pkg::ADDR_CMP_B))
			rd_val = cmp_b_r;
		else if (hit(ADR_I, timer_pkg::ADDR_STATUS)) begin
			rd_val[timer_pkg::BUF_NUM-1:0] = busy;
			rd_val[timer_pkg::ST_ASYNC_BIT] = async_r;
		end else if (hit(ADR_I, timer_pkg::ADDR_FLAGS))
			rd_val[2:0] = flags_r;
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ack_r <= 1'b0;
			dat_r <= '0;
		end else begin
			ack_r <= req & ~ack_r;
			if (req && !ack_r)
				dat_r <= {24'h000000, rd_val};
		end
	end

	// ----------------------------------------
	// Clock source and prescaler
	// ----------------------------------------
	assign osc_rise = OSC_IN_I & ~osc_d_r;
	assign src_tick = async_r ? osc_rise : 1'b1;
	assign OSC_PORT_DETACH_O = async_r;
	assign OSC_RUN_O = async_r & ~DEEP_SLEEP_I;
	assign psr_clr = wr_en & hit(ADR_I, timer_pkg::ADDR_GEN_CTRL) & DAT_I[timer_pkg::GEN_PSR_BIT];

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			osc_d_r <= 1'b0;
			async_r <= 1'b0;
		end else begin
			osc_d_r <= OSC_IN_I;
			if (wr_en && hit(ADR_I, timer_pkg::ADDR_STATUS))
				async_r <= DAT_I[timer_pkg::ST_ASYNC_BIT];
		end
	end

	presc_div u_presc (
		.clk_i(CLK_I),
		.rst_b_i(RST_B_I),
		.src_tick_i(src_tick),
		.clr_i(psr_clr),
		.sel_i(ctrl_b_r[2:0]),
		.tick_o(tick)
	);

	// ----------------------------------------
	// Buffered writes
	// ----------------------------------------
	for (genvar i = 0; i < timer_pkg::BUF_NUM; i++) begin : g_buf
		assign wr_buf[i] = wr_en & hit(ADR_I, buf_addr(i));
		write_xfer #(
			.W(8)
		) u_xfer (
			.clk_i(CLK_I),
			.rst_b_i(RST_B_I),
			.wr_i(wr_buf[i]),
			.wdata_i(DAT_I[7:0]),
			.edge_i(src_tick),
			.load_o(load[i]),
			.data_o(temp[i]),
			.busy_o(busy[i])
		);
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ctrl_a_r <= timer_pkg::RESET_VAL;
			ctrl_b_r <= timer_pkg::RESET_VAL;
			cmp_a_r <= timer_pkg::RESET_VAL;
			cmp_b_r <= timer_pkg::RESET_VAL;
		end else begin
			if (load[timer_pkg::BUF_CTRL_A])
				ctrl_a_r <= temp[timer_pkg::BUF_CTRL_A] & timer_pkg::CTRL_A_MASK;
			if (load[timer_pkg::BUF_CTRL_B])
				ctrl_b_r <= temp[timer_pkg::BUF_CTRL_B] & timer_pkg::CTRL_B_MASK;
			if (load[timer_pkg::BUF_CMP_A])
				cmp_a_r <= temp[timer_pkg::BUF_CMP_A];
			if (load[timer_pkg::BUF_CMP_B])
				cmp_b_r <= temp[timer_pkg::BUF_CMP_B];
		end
	end

	// ----------------------------------------
	// Mode decode and compare
	// ----------------------------------------
	assign mode = timer_pkg::wave_mode_t'({ctrl_b_r[3], ctrl_a_r[1:0]});
	assign com_a = timer_pkg::out_mode_t'(ctrl_a_r[7:6]);
	assign top = mode[2] | (mode == timer_pkg::WM_CTC) ? cmp_a_r : timer_pkg::CNT_MAX;
	assign at_top = (count_r == top);
	assign at_bot = (count_r == timer_pkg::CNT_BOTTOM);
	assign suppress = busy[timer_pkg::BUF_COUNT] | busy[timer_pkg::BUF_CMP_A]
		| busy[timer_pkg::BUF_CMP_B];
	assign match_a = tick & ~suppress & (count_r == cmp_a_r);
	assign match_b = tick & ~suppress & (count_r == cmp_b_r);

	always_comb begin
		evt = 3'h0;
		evt[timer_pkg::FLAG_CMP_A] = match_a;
		evt[timer_pkg::FLAG_CMP_B] = match_b;
		unique case (mode)
			timer_pkg::WM_PC_MAX, timer_pkg::WM_PC_CMP:
				evt[timer_pkg::FLAG_OVF] = tick & at_bot & down_r;
			timer_pkg::WM_FAST_MAX, timer_pkg::WM_FAST_CMP:
				evt[timer_pkg::FLAG_OVF] = tick & at_top;
			default:
				evt[timer_pkg::FLAG_OVF] = tick & (count_r == timer_pkg::CNT_MAX);
		endcase
	end

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			count_r <= timer_pkg::RESET_VAL;
			down_r <= 1'b0;
		end else if (load[timer_pkg::BUF_COUNT]) begin
			count_r <= temp[timer_pkg::BUF_COUNT];
		end else if (tick) begin
			unique case (mode)
				timer_pkg::WM_NORMAL:
					count_r <= count_r + 8'h01;
				timer_pkg::WM_CTC, timer_pkg::WM_FAST_MAX, timer_pkg::WM_FAST_CMP:
					count_r <= at_top ? timer_pkg::CNT_BOTTOM : count_r + 8'h01;
				timer_pkg::WM_PC_MAX, timer_pkg::WM_PC_CMP: begin
					if (!down_r && at_top) begin
						down_r <= 1'b1;
						count_r <= count_r - 8'h01;
					end else if (down_r && at_bot) begin
						down_r <= 1'b0;
						count_r <= count_r + 8'h01;
					end else
						count_r <= down_r ? count_r - 8'h01 : count_r + 8'h01;
				end
				timer_pkg::WM_RSV4, timer_pkg::WM_RSV6:
					count_r <= count_r;
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			count_rd_r <= timer_pkg::RESET_VAL;
		else if (src_tick && !SLEEP_I)
			count_rd_r <= count_r;
	end

	// ----------------------------------------
	// Channel A output
	// ----------------------------------------
	assign CHAN_A_OVERRIDE_O = (com_a != timer_pkg::OM_OFF);
	assign CHAN_A_OE_O = CHAN_A_OVERRIDE_O & PIN_DIR_I;
	assign CHAN_A_OUT_O = oc_r;

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			oc_r <= 1'b0;
		else if (tick) begin
			unique case (mode)
				timer_pkg::WM_FAST_MAX, timer_pkg::WM_FAST_CMP: begin
					if (com_a[1]) begin
						if (at_top)
							oc_r <= ~com_a[0];
						else if (match_a)
							oc_r <= com_a[0];
					end else if (com_a == timer_pkg::OM_TOGGLE && mode[2] && match_a)
						oc_r <= ~oc_r;
				end
				timer_pkg::WM_PC_MAX, timer_pkg::WM_PC_CMP: begin
					if (com_a[1] && match_a)
						oc_r <= down_r ? ~com_a[0] : com_a[0];
					else if (com_a == timer_pkg::OM_TOGGLE && mode[2] && match_a)
						oc_r <= ~oc_r;
				end
				default: begin
					if (match_a) begin
						unique case (com_a)
							timer_pkg::OM_OFF: oc_r <= oc_r;
							timer_pkg::OM_TOGGLE: oc_r <= ~oc_r;
							timer_pkg::OM_CLEAR: oc_r <= 1'b0;
							timer_pkg::OM_SET: oc_r <= 1'b1;
						endcase
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Flag synchronisation
	// ----------------------------------------
	assign TIMER_FLAGS_O = flags_r;

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			for (int k = 0; k < timer_pkg::FLAG_SYNC_CYCLES; k++)
				evt_d_r[k] <= 3'h0;
			flags_r <= 3'h0;
		end else begin
			evt_d_r[0] <= evt;
			for (int k = 1; k < timer_pkg::FLAG_SYNC_CYCLES; k++)
				evt_d_r[k] <= evt_d_r[k-1];
			if (wr_en && hit(ADR_I, timer_pkg::ADDR_FLAGS))
				flags_r <= (flags_r & ~DAT_I[2:0])
					| evt_d_r[timer_pkg::FLAG_SYNC_CYCLES-1];
			else
				flags_r <= flags_r | evt_d_r[timer_pkg::FLAG_SYNC_CYCLES-1];
		end
	end

	// ----------------------------------------
	// Sleep wake-up
	// ----------------------------------------
	assign WAKE_O = wake_r;
	assign CPU_HALT_O = (halt_cnt_r != 3'h0);

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			wake_arm_r <= 1'b0;
			wake_r <= 1'b0;
			halt_cnt_r <= 3'h0;
		end else begin
			wake_r <= 1'b0;
			if (wake_arm_r && tick) begin
				wake_arm_r <= 1'b0;
				wake_r <= 1'b1;
			end else if (SLEEP_I && (evt != 3'h0))
				wake_arm_r <= 1'b1;
			if (wake_r)
				halt_cnt_r <= timer_pkg::WAKE_STALL_CYCLES;
			else if (halt_cnt_r != 3'h0)
				halt_cnt_r <= halt_cnt_r - 3'h1;
		end
	end
endmodule
`default_nettype wire

/* dv/async_timer_monitor.sv */
// Concurrent checks on the timer's bus answer, pin and wake outputs.
// Assumes it is bound into async_timer and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module async_timer_monitor (
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic CYC_I,
	input wire logic STB_I,
	input wire logic WE_I,
	input wire logic [7:0] ADR_I,
	input wire logic [31:0] DAT_O,
	input wire logic ACK_O,
	input wire logic PIN_DIR_I,
	input wire logic DEEP_SLEEP_I,
	input wire logic CHAN_A_OE_O,
	input wire logic CHAN_A_OVERRIDE_O,
	input wire logic OSC_PORT_DETACH_O,
	input wire logic OSC_RUN_O,
	input wire logic WAKE_O,
	input wire logic CPU_HALT_O
);
	// ----------------------------------------
	// Sequences and assertions
	// ----------------------------------------
	default clocking dc @(posedge CLK_I);
	endclocking
	default disable iff (!RST_B_I);
	sequence req_s;
		CYC_I && STB_I && !ACK_O;
	endsequence
	sequence halt_s;
		CPU_HALT_O [*4] ##1 !CPU_HALT_O;
	endsequence
	a_ack_next: assert property (req_s |=> ACK_O ##1 !ACK_O)
		else $error("ack not one cycle after request");
	a_read_upper: assert property (ACK_O && !WE_I |-> DAT_O[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	a_oe_gating: assert property (CHAN_A_OE_O == (CHAN_A_OVERRIDE_O && PIN_DIR_I))
		else $error("output enable not override and direction");
	a_run_select: assert property (OSC_RUN_O |-> OSC_PORT_DETACH_O)
		else $error("oscillator runs without async select");
	a_osc_deep: assert property (DEEP_SLEEP_I |-> !OSC_RUN_O)
		else $error("oscillator runs in deep sleep");
	a_osc_keeps: assert property (OSC_PORT_DETACH_O && !DEEP_SLEEP_I |-> OSC_RUN_O)
		else $error("oscillator stopped in light sleep");
	a_detach_write: assert property ($changed(OSC_PORT_DETACH_O)
		|-> $past(ACK_O && WE_I && ADR_I == timer_pkg::ADDR_STATUS))
		else $error("port detach changed without status write");
	a_halt_four: assert property (WAKE_O |=> halt_s)
		else $error("halt not four cycles after wake");
	a_halt_cause: assert property ($rose(CPU_HALT_O) |-> $past(WAKE_O))
		else $error("halt without wake");
	a_wake_pulse: assert property (WAKE_O |=> !WAKE_O)
		else $error("wake longer than one cycle");
endmodule
bind async_timer async_timer_monitor u_mon (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .CYC_I(CYC_I),
	.STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
	.PIN_DIR_I(PIN_DIR_I), .DEEP_SLEEP_I(DEEP_SLEEP_I), .CHAN_A_OE_O(CHAN_A_OE_O),
	.CHAN_A_OVERRIDE_O(CHAN_A_OVERRIDE_O), .OSC_PORT_DETACH_O(OSC_PORT_DETACH_O),
	.OSC_RUN_O(OSC_RUN_O), .WAKE_O(WAKE_O), .CPU_HALT_O(CPU_HALT_O));
`default_nettype wire

/* dv/async_timer_test.sv */
// Self-checking bench of the asynchronous timer.
// Assumes the bench is the Wishbone master and drives the oscillator pin.
`timescale 1ns/10ps
`default_nettype none
module async_timer_test;
	logic clk, rst_b, cyc, stb, we, osc, dir, slp, deep;
	logic [7:0] adr, q;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, hi, tr;
	logic ack, out_a, oe_a, ovr_a, detach, run, wake, halt;
	logic [2:0] flags;
	int n_errors, checks;
	async_timer dut (.CLK_I(clk), .RST_B_I(rst_b), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
		.ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .OSC_IN_I(osc),
		.PIN_DIR_I(dir), .SLEEP_I(slp), .DEEP_SLEEP_I(deep), .CHAN_A_OUT_O(out_a),
		.CHAN_A_OE_O(oe_a), .CHAN_A_OVERRIDE_O(ovr_a), .OSC_PORT_DETACH_O(detach),
		.OSC_RUN_O(run), .TIMER_FLAGS_O(flags), .WAKE_O(wake), .CPU_HALT_O(halt));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic test_done();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic near(input logic [31:0] seen, input int exp, input int w);
		chk(32'(seen >= exp - w && seen <= exp + w), 32'h1);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] r);
		int i;
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (ack !== 1'h1 && i < 20);
		if (ack !== 1'h1) begin
			n_errors++;
			test_done();
		end
		r = rdat[7:0];
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
		@(posedge clk);
	endtask
	task automatic tick();
		osc <= 1'h1;
		repeat (3) @(posedge clk);
		osc <= 1'h0;
		repeat (3) @(posedge clk);
	endtask
	task automatic settle();
		int i;
		for (i = 0; i < 30; i++) begin
			tick();
			bus(1'h0, timer_pkg::ADDR_STATUS, 8'h00, q);
			if (q[4:0] === 5'h00) return;
		end
		n_errors++;
		test_done();
	endtask
	task automatic cfg(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		bus(1'h1, timer_pkg::ADDR_CTRL_B, b, q);
		bus(1'h1, timer_pkg::ADDR_CMP_A, c, q);
		bus(1'h1, timer_pkg::ADDR_CTRL_A, a, q);
		settle();
		repeat (1100) @(posedge clk);
	endtask
	task automatic meas(input int n);
		logic p;
		hi = 32'h0;
		tr = 32'h0;
		p = out_a;
		repeat (n) begin
			@(posedge clk);
			hi += out_a;
			tr += (out_a != p);
			p = out_a;
		end
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		logic [7:0] a;
		for (a = 8'hB0; a <= 8'hCC; a += 8'h04) begin
			bus(1'h0, a, 8'h00, q);
			chk(q, 32'h0);
		end
		bus(1'h1, 8'hF0, 8'hFF, q);
		bus(1'h0, 8'hF0, 8'h00, q);
		chk(q, 32'h0);
		sel <= 4'hE;
		bus(1'h1, timer_pkg::ADDR_CMP_A, 8'h55, q);
		sel <= 4'hF;
		bus(1'h0, timer_pkg::ADDR_STATUS, 8'h00, q);
		chk(q, 32'h0);
		chk({detach, run, ovr_a, oe_a}, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_async();
		bus(1'h1, timer_pkg::ADDR_STATUS, 8'h20, q);
		chk({detach, run}, 32'h3);
		bus(1'h1, timer_pkg::ADDR_CMP_A, 8'h5A, q);
		bus(1'h1, timer_pkg::ADDR_CMP_B, 8'hA5, q);
		bus(1'h0, timer_pkg::ADDR_STATUS, 8'h00, q);
		chk(q, 32'h2C);
		tick();
		bus(1'h0, timer_pkg::ADDR_CMP_A, 8'h00, q);
		chk(q, 32'h0);
		settle();
		bus(1'h0, timer_pkg::ADDR_CMP_A, 8'h00, q);
		chk(q, 32'h5A);
		bus(1'h0, timer_pkg::ADDR_CMP_B, 8'h00, q);
		chk(q, 32'hA5);
		deep <= 1'h1;
		@(posedge clk);
		@(posedge clk);
		chk(run, 32'h0);
		deep <= 1'h0;
		bus(1'h1, timer_pkg::ADDR_STATUS, 8'h00, q);
		chk(detach, 32'h0);
		$display("async transfer test done");
	endtask
	task automatic t_presc();
		int div[8] = '{1, 1, 8, 32, 64, 128, 256, 1024};
		int s, m;
		logic [7:0] c0;
		for (s = 0; s < 8; s++) begin
			m = div[s] * 8 + 56;
			bus(1'h1, timer_pkg::ADDR_CTRL_B, s[7:0], q);
			settle();
			bus(1'h1, timer_pkg::ADDR_GEN_CTRL, 8'h02, q);
			bus(1'h0, timer_pkg::ADDR_COUNT, 8'h00, c0);
			repeat (m) @(posedge clk);
			bus(1'h0, timer_pkg::ADDR_COUNT, 8'h00, q);
			near(8'(q - c0), (s == 0) ? 0 : (m + 3) / div[s], (s == 0) ? 0 : 1);
		end
		bus(1'h0, timer_pkg::ADDR_GEN_CTRL, 8'h00, q);
		chk(q, 32'h0);
		$display("prescaler test done");
	endtask
	task automatic t_fast();
		cfg(8'h83, 8'h01, 8'h40);
		meas(256);
		near(hi, 65, 1);
		chk(tr, 32'h2);
		cfg(8'hC3, 8'h01, 8'h40);
		meas(256);
		near(hi, 191, 1);
		cfg(8'h43, 8'h01, 8'h40);
		meas(256);
		chk(tr, 32'h0);
		cfg(8'h43, 8'h09, 8'h1F);
		meas(256);
		chk(tr, 32'h8);
		cfg(8'h83, 8'h09, 8'h1F);
		meas(256);
		chk(hi, 32'h100);
		$display("fast pwm test done");
	endtask
	task automatic t_phase();
		cfg(8'h81, 8'h01, 8'h40);
		meas(510);
		near(hi, 128, 2);
		cfg(8'hC1, 8'h01, 8'h40);
		meas(510);
		near(hi, 382, 2);
		cfg(8'h41, 8'h09, 8'h10);
		meas(320);
		chk(tr, 32'hA);
		$display("phase correct test done");
	endtask
	task automatic t_ctc();
		logic [7:0] c0;
		cfg(8'h42, 8'h01, 8'h0F);
		meas(320);
		chk(tr, 32'h14);
		cfg(8'hC2, 8'h01, 8'h0F);
		meas(64);
		chk(hi, 32'h40);
		cfg(8'h82, 8'h01, 8'h0F);
		meas(64);
		chk(hi, 32'h0);
		chk({ovr_a, oe_a}, 32'h3);
		dir <= 1'h0;
		@(posedge clk);
		@(posedge clk);
		chk({ovr_a, oe_a}, 32'h2);
		cfg(8'h02, 8'h01, 8'h0F);
		chk(ovr_a, 32'h0);
		cfg(8'h00, 8'h09, 8'h0F);
		bus(1'h0, timer_pkg::ADDR_COUNT, 8'h00, c0);
		repeat (20) @(posedge clk);
		bus(1'h0, timer_pkg::ADDR_COUNT, 8'h00, q);
		chk(q, c0);
		$display("ctc test done");
	endtask
	task automatic t_wake();
		int i;
		logic [31:0] n;
		cfg(8'h00, 8'h01, 8'h80);
		bus(1'h1, timer_pkg::ADDR_COUNT, 8'hE0, q);
		settle();
		bus(1'h1, timer_pkg::ADDR_FLAGS, 8'h07, q);
		slp <= 1'h1;
		for (i = 0; i < 600 && wake !== 1'h1; i++) @(posedge clk);
		chk(wake, 32'h1);
		n = 32'h0;
		repeat (8) begin
			@(posedge clk);
			n += halt;
		end
		chk(n, 32'h4);
		slp <= 1'h0;
		bus(1'h0, timer_pkg::ADDR_FLAGS, 8'h00, q);
		chk(q[0], 32'h1);
		bus(1'h1, timer_pkg::ADDR_CTRL_B, 8'h00, q);
		settle();
		bus(1'h1, timer_pkg::ADDR_FLAGS, 8'h07, q);
		bus(1'h0, timer_pkg::ADDR_FLAGS, 8'h00, q);
		chk({q, 5'h00, flags}, 32'h0);
		$display("wake test done");
	endtask
	initial begin
		clk = 1'h0;
		forever #2 clk = ~clk;
	end
	initial begin
		{rst_b, cyc, stb, we, osc, slp, deep} = 7'h00;
		adr = 8'h00;
		wdat = 32'h0;
		sel = 4'hF;
		dir = 1'h1;
		n_errors = 0;
		checks = 0;
		repeat (10) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
		t_reset();
		t_async();
		t_presc();
		t_fast();
		t_phase();
		t_ctc();
		t_wake();
		test_done();
	end
endmodule
`default_nettype wire
